// File: pse_pkg.sv
/*
 Package for the PHY status extension and bypass register group:
 register offsets, field positions, reset values and the carrier types.
 Assumes the management interface delivers 5-bit register addresses.
*/
`default_nettype none
package pse_pkg;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 16;

   localparam logic [4:0] OFF_RSVD_FIRST  = 5'h0b;
   localparam logic [4:0] OFF_RSVD_LAST   = 5'h0e;
   localparam logic [4:0] OFF_GIG_EXT_ONE = 5'h0f;
   localparam logic [4:0] OFF_FE_EXT      = 5'h10;
   localparam logic [4:0] OFF_GIG_EXT_TWO = 5'h11;
   localparam logic [4:0] OFF_BYPASS      = 5'h12;

   localparam logic [15:0] GIG_EXT_ONE_VAL = 16'h3000;

   // status field positions (bits 15 to 8 shared by both status extension registers, bits 7 to 5 gigabit register only)
   localparam int unsigned BIT_DESCR_LOCK = 15;
   localparam int unsigned BIT_LOCK_ERR   = 14;
   localparam int unsigned BIT_DISCONNECT = 13;
   localparam int unsigned BIT_LINK_UP    = 12;
   localparam int unsigned BIT_RX_ERR     = 11;
   localparam int unsigned BIT_TX_ERR     = 10;
   localparam int unsigned BIT_SSD_ERR    = 9;
   localparam int unsigned BIT_ESD_ERR    = 8;
   localparam int unsigned BIT_CEXT_ERR   = 7;
   localparam int unsigned BIT_LEGACY     = 6;
   localparam int unsigned BIT_XOVER_ERR  = 5;

   // bypass control field positions
   localparam int unsigned BIT_TX_DISABLE  = 15;
   localparam int unsigned BIT_TX_TEST_CLK = 8;
   localparam int unsigned BIT_FORCE_LEG   = 7;
   localparam int unsigned BIT_LEG_DET_OFF = 6;
   localparam int unsigned BIT_PAIR_OFF    = 5;
   localparam int unsigned BIT_POL_OFF     = 4;
   localparam int unsigned BIT_PAR_DET     = 3;
   localparam int unsigned BIT_AUTO_NP_OFF = 1;
   localparam int unsigned BIT_CLOCK_OUTPUT_PIN_EN   = 0;

   localparam logic RST_TX_DISABLE  = 1'b0;
   localparam logic RST_TX_TEST_CLK = 1'b0;
   localparam logic RST_FORCE_LEG   = 1'b0;
   localparam logic RST_LEG_DET_OFF = 1'b1;
   localparam logic RST_PAIR_OFF    = 1'b0;
   localparam logic RST_POL_OFF     = 1'b0;
   localparam logic RST_PAR_DET     = 1'b1;
   localparam logic RST_AUTO_NP_OFF = 1'b0;

   typedef struct packed {
      logic lock_err;
      logic disconnect;
      logic rx_err;
      logic tx_err;
      logic ssd_err;
      logic esd_err;
   } pse_evt_t;

   typedef struct packed {
      logic descr_lock;
      logic link_up;
   } pse_live_t;

   typedef struct packed {
      logic tx_disable;
      logic tx_test_clk;
      logic force_legacy;
      logic legacy_det_off;
      logic pair_swap_off;
      logic polarity_off;
      logic par_det_honour;
      logic auto_np_off;
      logic clock_output_pin_en;
   } pse_ctrl_t;

   typedef enum logic {NP_AUTO, NP_HOST} pse_np_t;
endpackage
`default_nettype wire

// File: pse_regs.sv
/*
 Status extension and bypass control registers of the PHY management page.
 Assumes register reads and writes arrive as one-cycle strobes on i_clock,
 event inputs are one-cycle pulses and live inputs are levels, all
 synchronous to i_clock.
*/
`timescale 1ns/10ps
`default_nettype none
module pse_regs (
   input  wire logic                     i_clock,
   input  wire logic                     i_resetn,
   input  wire logic                     i_soft_reset,
   input  wire logic                     i_config_strap_pins,
   input  wire logic [pse_pkg::ADDR_W-1:0] i_reg_addr,
   input  wire logic                     i_reg_rd,
   input  wire logic                     i_reg_wr,
   input  wire logic [pse_pkg::DATA_W-1:0] i_reg_wdata,
   input  wire pse_pkg::pse_live_t       i_fe_live,
   input  wire pse_pkg::pse_evt_t        i_fe_evt,
   input  wire pse_pkg::pse_live_t       i_gig_live,
   input  wire pse_pkg::pse_evt_t        i_gig_evt,
   input  wire logic                     i_gig_cext_err,
   input  wire logic                     i_legacy_partner,
   input  wire logic                     i_xover_err,
   input  wire logic                     i_base_page_done,
   input  wire logic                     i_an_restart,
   output logic [pse_pkg::DATA_W-1:0]    o_reg_rdata,
   output pse_pkg::pse_ctrl_t            o_ctrl,
   output logic                          o_np_host_ctrl
);
   import pse_pkg::*;

   pse_evt_t  fe_lat_ff;
   pse_evt_t  gig_lat_ff;
   logic      cext_lat_ff;
   pse_ctrl_t ctrl_ff;
   logic [1:0]  plain_ff;
   logic [5:0]  sticky_ff;
   logic        clock_output_pin_ff;
   logic      strap_done_ff;
   pse_np_t   np_state_ff;
   pse_np_t   nxt_np_state;
   logic      np_host_ff;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   logic      legacy_seen;
   logic      wr_byp;
   logic      rd_fe;
   logic      rd_gig;

   assign wr_byp = i_reg_wr && (i_reg_addr == OFF_BYPASS);
   assign rd_fe  = i_reg_rd && (i_reg_addr == OFF_FE_EXT);
   assign rd_gig = i_reg_rd && (i_reg_addr == OFF_GIG_EXT_TWO);

   // bypass fields gathered in struct order, one driver per flop group
   assign ctrl_ff = {plain_ff, sticky_ff, clock_output_pin_ff};

   assign legacy_seen = ctrl_ff.force_legacy ||
                        (i_legacy_partner && !ctrl_ff.legacy_det_off);

   // place latched flags and live bits into a status word
   function automatic logic [15:0] status_word(input pse_live_t live,
                                               input pse_evt_t  lat);
      logic [15:0] w;
      w = 16'h0000;
      w[BIT_DESCR_LOCK] = live.descr_lock;
      w[BIT_LOCK_ERR]   = lat.lock_err;
      w[BIT_DISCONNECT] = lat.disconnect;
      w[BIT_LINK_UP]    = live.link_up;
      w[BIT_RX_ERR]     = lat.rx_err;
      w[BIT_TX_ERR]     = lat.tx_err;
      w[BIT_SSD_ERR]    = lat.ssd_err;
      w[BIT_ESD_ERR]    = lat.esd_err;
      return w;
   endfunction

   // event set wins over read clear
   function automatic pse_evt_t latch_next(input pse_evt_t cur,
                                           input pse_evt_t evt,
                                           input logic     clr);
      return clr ? evt : (cur | evt);
   endfunction

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         fe_lat_ff <= '0;
      end else if (i_soft_reset) begin
         fe_lat_ff <= '0;
      end else begin
         fe_lat_ff <= latch_next(fe_lat_ff, i_fe_evt, rd_fe);
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         gig_lat_ff  <= '0;
         cext_lat_ff <= 1'b0;
      end else if (i_soft_reset) begin
         gig_lat_ff  <= '0;
         cext_lat_ff <= 1'b0;
      end else begin
         gig_lat_ff  <= latch_next(gig_lat_ff, i_gig_evt, rd_gig);
         cext_lat_ff <= i_gig_cext_err || (cext_lat_ff && !rd_gig);
      end
   end

   // non-sticky bypass bits: hardware and software reset
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         plain_ff[1] <= RST_TX_DISABLE;
         plain_ff[0] <= RST_TX_TEST_CLK;
      end else if (i_soft_reset) begin
         plain_ff[1] <= RST_TX_DISABLE;
         plain_ff[0] <= RST_TX_TEST_CLK;
      end else if (wr_byp) begin
         plain_ff[1] <= i_reg_wdata[BIT_TX_DISABLE];
         plain_ff[0] <= i_reg_wdata[BIT_TX_TEST_CLK];
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         sticky_ff[5] <= RST_FORCE_LEG;
         sticky_ff[4] <= RST_LEG_DET_OFF;
         sticky_ff[3] <= RST_PAIR_OFF;
         sticky_ff[2] <= RST_POL_OFF;
         sticky_ff[1] <= RST_PAR_DET;
         sticky_ff[0] <= RST_AUTO_NP_OFF;
      end else if (wr_byp) begin
         sticky_ff[5] <= i_reg_wdata[BIT_FORCE_LEG];
         sticky_ff[4] <= i_reg_wdata[BIT_LEG_DET_OFF];
         sticky_ff[3] <= i_reg_wdata[BIT_PAIR_OFF];
         sticky_ff[2] <= i_reg_wdata[BIT_POL_OFF];
         sticky_ff[1] <= i_reg_wdata[BIT_PAR_DET];
         sticky_ff[0] <= i_reg_wdata[BIT_AUTO_NP_OFF];
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         strap_done_ff <= 1'b0;
         clock_output_pin_ff     <= 1'b0;
      end else if (!strap_done_ff) begin
         strap_done_ff <= 1'b1;
         clock_output_pin_ff     <= i_config_strap_pins;
      end else if (wr_byp) begin
         clock_output_pin_ff     <= i_reg_wdata[BIT_CLOCK_OUTPUT_PIN_EN];
      end
   end

   // hand negotiation to host after base page
   always_comb begin
      nxt_np_state = np_state_ff;
      case (np_state_ff)
         NP_AUTO: begin
            if (ctrl_ff.auto_np_off && i_base_page_done) begin
               nxt_np_state = NP_HOST;
            end
         end
         NP_HOST: begin
            if (i_an_restart) begin
               nxt_np_state = NP_AUTO;
            end
         end
         default: nxt_np_state = NP_AUTO;
      endcase
      if (i_soft_reset) begin
         nxt_np_state = NP_AUTO;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         np_state_ff <= NP_AUTO;
         np_host_ff  <= 1'b0;
      end else begin
         np_state_ff <= nxt_np_state;
         np_host_ff  <= (nxt_np_state == NP_HOST);
      end
   end

   // read data, valid the cycle after the read strobe
   always_comb begin
      nxt_rdata = rdata_ff;
      if (i_reg_rd) begin
         nxt_rdata = 16'h0000;
         case (i_reg_addr)
            OFF_GIG_EXT_ONE: nxt_rdata = GIG_EXT_ONE_VAL;
            OFF_FE_EXT: nxt_rdata = status_word(i_fe_live, fe_lat_ff);
            OFF_GIG_EXT_TWO: begin
               nxt_rdata = status_word(i_gig_live, gig_lat_ff);
               nxt_rdata[BIT_CEXT_ERR] = cext_lat_ff;
               nxt_rdata[BIT_LEGACY]    = legacy_seen;
               nxt_rdata[BIT_XOVER_ERR] = i_xover_err;
            end
            OFF_BYPASS: begin
               nxt_rdata[BIT_TX_DISABLE]  = ctrl_ff.tx_disable;
               nxt_rdata[BIT_TX_TEST_CLK] = ctrl_ff.tx_test_clk;
               nxt_rdata[BIT_FORCE_LEG]   = ctrl_ff.force_legacy;
               nxt_rdata[BIT_LEG_DET_OFF] = ctrl_ff.legacy_det_off;
               nxt_rdata[BIT_PAIR_OFF]    = ctrl_ff.pair_swap_off;
               nxt_rdata[BIT_POL_OFF]     = ctrl_ff.polarity_off;
               nxt_rdata[BIT_PAR_DET]     = ctrl_ff.par_det_honour;
               nxt_rdata[BIT_AUTO_NP_OFF] = ctrl_ff.auto_np_off;
               nxt_rdata[BIT_CLOCK_OUTPUT_PIN_EN]   = ctrl_ff.clock_output_pin_en;
            end
            default: nxt_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_ff <= 16'h0000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign o_reg_rdata    = rdata_ff;
   assign o_ctrl         = ctrl_ff;
   assign o_np_host_ctrl = np_host_ff;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   chk_rsvd_read_zero: assert property (
      i_reg_rd && i_reg_addr >= OFF_RSVD_FIRST &&
      i_reg_addr <= OFF_RSVD_LAST |=> o_reg_rdata == 16'h0000)
      else $error("reserved address read nonzero");
   chk_gig_tp_caps: assert property (
      i_reg_rd && i_reg_addr == OFF_GIG_EXT_ONE
      |=> o_reg_rdata[13:12] == 2'b11 && o_reg_rdata[11:0] == 12'h000)
      else $error("twisted pair capability bits wrong");
   chk_gig_fibre_caps: assert property (
      i_reg_rd && i_reg_addr == OFF_GIG_EXT_ONE
      |=> o_reg_rdata[15:14] == 2'b00)
      else $error("fibre capability bits set");
   chk_fe_live_bits: assert property (
      rd_fe |=> o_reg_rdata[15] == $past(i_fe_live.descr_lock) &&
      o_reg_rdata[12] == $past(i_fe_live.link_up))
      else $error("fast live status wrong");
   chk_fe_flag_latch: assert property (
      i_fe_evt.ssd_err && !i_soft_reset
      |=> (fe_lat_ff.ssd_err and (rd_fe |=> o_reg_rdata[9])))
      else $error("fast flag not latched");
   chk_gig_live_bits: assert property (
      rd_gig |=> o_reg_rdata[15] == $past(i_gig_live.descr_lock) &&
      o_reg_rdata[12] == $past(i_gig_live.link_up))
      else $error("gig live status wrong");
   chk_gig_flag_latch: assert property (
      i_gig_evt.lock_err && !i_soft_reset && !i_gig_evt.esd_err
      |=> gig_lat_ff.lock_err)
      else $error("gig flag not latched");
   chk_cext_latch: assert property (
      i_gig_cext_err && !i_soft_reset |=> cext_lat_ff)
      else $error("carrier extension error lost");
   chk_legacy_report: assert property (
      rd_gig |=> o_reg_rdata[6] == $past(legacy_seen) &&
      o_reg_rdata[5] == $past(i_xover_err) && o_reg_rdata[4:0] == 5'h00)
      else $error("legacy or crossover bit wrong");
   chk_tx_disable_wr: assert property (
      wr_byp && !i_soft_reset |=>
      o_ctrl.tx_disable == $past(i_reg_wdata[15]))
      else $error("transmit disable not written");
   chk_np_handover: assert property (
      np_state_ff == NP_AUTO && ctrl_ff.auto_np_off && i_base_page_done &&
      !i_soft_reset |=> o_np_host_ctrl)
      else $error("no handover after base page");
   chk_read_clears: assert property (
      rd_fe && i_fe_evt == '0 |=> fe_lat_ff == '0)
      else $error("read did not clear flags");
   chk_sticky_kept: assert property (
      i_soft_reset && !i_reg_wr |=> $stable(o_ctrl.pair_swap_off) &&
      $stable(o_ctrl.auto_np_off) && o_ctrl.tx_disable == 1'b0)
      else $error("software reset changed sticky bit");
   chk_set_wins_clear: assert property (
      rd_gig && i_gig_evt.rx_err && !i_soft_reset |=> gig_lat_ff.rx_err)
      else $error("event lost to read clear");
   chk_strap_capture: assert property (
      !strap_done_ff |=> o_ctrl.clock_output_pin_en == $past(i_config_strap_pins))
      else $error("clock output enable missed strap level");

   cov_read_clear_race: cover property (rd_gig && i_gig_evt.rx_err);
   cov_handover: cover property (o_np_host_ctrl ##1 i_an_restart);
   cov_soft_reset: cover property (ctrl_ff.polarity_off && i_soft_reset);
endmodule
`default_nettype wire

// File: pse_host_model.sv
/*
 Station management host model for the register strobe port.
 Assumes the register block shares i_clock and answers a read one
 cycle after the strobe edge.
*/
`timescale 1ns/10ps
`default_nettype none
module pse_host_model (
   input  wire logic                       i_clock,
   input  wire logic [pse_pkg::DATA_W-1:0] i_reg_rdata,
   output logic [pse_pkg::ADDR_W-1:0]      o_reg_addr,
   output logic                            o_reg_rd,
   output logic                            o_reg_wr,
   output logic [pse_pkg::DATA_W-1:0]      o_reg_wdata
);
   import pse_pkg::*;
   initial begin
      o_reg_addr  = 5'h00;
      o_reg_rd    = 1'b0;
      o_reg_wr    = 1'b0;
      o_reg_wdata = 16'h0000;
   end
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge i_clock);
      o_reg_addr  <= a;
      o_reg_wdata <= d;
      o_reg_wr    <= 1'b1;
      @(posedge i_clock);
      o_reg_wr    <= 1'b0;
      o_reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge i_clock);
      o_reg_addr <= a;
      o_reg_rd   <= 1'b1;
      @(posedge i_clock);
      o_reg_rd   <= 1'b0;
      #1;
      d = i_reg_rdata;
   endtask
   task automatic force_cfg(input logic [15:0] d);
      wr(OFF_BYPASS, d);
   endtask
endmodule
`default_nettype wire

// File: phy_status_ext_and_bypass_regs_tb_top.sv
/*
 Self-checking bench for the status extension and bypass registers.
 Assumes pse_pkg, pse_regs and pse_host_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module phy_status_ext_and_bypass_regs_tb_top;
   import pse_pkg::*;
   logic        clock = 1'b0;
   logic        resetn = 1'b0;
   logic        soft_reset = 1'b0;
   logic        strap = 1'b1;
   pse_live_t   fe_live = '0;
   pse_live_t   gig_live = '0;
   pse_evt_t    fe_evt = '0;
   pse_evt_t    gig_evt = '0;
   logic        cext = 1'b0;
   logic        legacy = 1'b0;
   logic        xover = 1'b0;
   logic        page_done = 1'b0;
   logic        restart = 1'b0;
   logic [4:0]  addr;
   logic        rd;
   logic        wr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   pse_ctrl_t   ctrl;
   logic        np_host;
   int          errors = 0;
   int          checks = 0;
   int          cycles = 0;
   int          ctrl_pos [9] = '{0, 1, 3, 4, 5, 6, 7, 8, 15};

   always #20 clock = ~clock;

   pse_regs u_dut (.i_clock(clock), .i_resetn(resetn),
      .i_soft_reset(soft_reset), .i_config_strap_pins(strap),
      .i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr),
      .i_reg_wdata(wdata), .i_fe_live(fe_live), .i_fe_evt(fe_evt),
      .i_gig_live(gig_live), .i_gig_evt(gig_evt),
      .i_gig_cext_err(cext), .i_legacy_partner(legacy),
      .i_xover_err(xover), .i_base_page_done(page_done),
      .i_an_restart(restart), .o_reg_rdata(rdata), .o_ctrl(ctrl),
      .o_np_host_ctrl(np_host));

   pse_host_model u_host (.i_clock(clock), .i_reg_rdata(rdata),
      .o_reg_addr(addr), .o_reg_rd(rd), .o_reg_wr(wr),
      .o_reg_wdata(wdata));

   task automatic final_report;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] d;
      u_host.rd(a, d);
      check(d, exp);
   endtask

   task automatic ev(input pse_evt_t f, input pse_evt_t g, input logic c);
      @(posedge clock);
      fe_evt  <= f;
      gig_evt <= g;
      cext    <= c;
      @(posedge clock);
      fe_evt  <= '0;
      gig_evt <= '0;
      cext    <= 1'b0;
   endtask

   task automatic pg(input logic d, input logic r);
      @(posedge clock);
      page_done <= d;
      restart   <= r;
      @(posedge clock);
      page_done <= 1'b0;
      restart   <= 1'b0;
      #1;
   endtask

   task automatic t_reset_values;
      rdc(OFF_BYPASS, 16'h0049);
      check({7'h00, ctrl}, 16'h0025);
      rdc(OFF_GIG_EXT_ONE, GIG_EXT_ONE_VAL);
      for (int a = 0; a < 32; a++)
         if (a < 15 || a > 18) rdc(5'(a), 16'h0000);
   endtask

   task automatic t_live;
      for (int j = 0; j < 4; j++) begin
         @(posedge clock);
         fe_live  <= pse_live_t'(j[1:0]);
         gig_live <= pse_live_t'(~j[1:0]);
         rdc(OFF_FE_EXT, {j[1], 2'b00, j[0], 12'h000});
         rdc(OFF_GIG_EXT_TWO, {~j[1], 2'b00, ~j[0], 12'h000});
      end
      @(posedge clock);
      fe_live <= '0;
   endtask

   task automatic t_events;
      for (int i = 0; i < 6; i++) begin
         ev(pse_evt_t'(6'h1 << i), '0, 1'b0);
         rdc(OFF_FE_EXT, 16'h1 << (i < 4 ? 8 + i : 9 + i));
         rdc(OFF_FE_EXT, 16'h0000);
         ev('0, pse_evt_t'(6'h1 << i), 1'b0);
         rdc(OFF_GIG_EXT_TWO, 16'h1 << (i < 4 ? 8 + i : 9 + i));
         rdc(OFF_GIG_EXT_TWO, 16'h0000);
      end
      ev('0, '0, 1'b1);
      rdc(OFF_GIG_EXT_TWO, 16'h1 << BIT_CEXT_ERR);
      rdc(OFF_GIG_EXT_TWO, 16'h0000);
      // event and clearing read on one edge: the event survives
      fork
         ev('0, pse_evt_t'(6'h08), 1'b0);
         rdc(OFF_GIG_EXT_TWO, 16'h0000);
      join
      rdc(OFF_GIG_EXT_TWO, 16'h0800);
      rdc(OFF_GIG_EXT_TWO, 16'h0000);
   endtask

   task automatic t_legacy;
      @(posedge clock);
      legacy <= 1'b1;
      xover  <= 1'b1;
      rdc(OFF_GIG_EXT_TWO, 16'h0020);
      u_host.wr(OFF_BYPASS, 16'h0009);
      rdc(OFF_GIG_EXT_TWO, 16'h0060);
      @(posedge clock);
      legacy <= 1'b0;
      xover  <= 1'b0;
      u_host.wr(OFF_BYPASS, 16'h00c9);
      rdc(OFF_GIG_EXT_TWO, 16'h0040);
   endtask

   task automatic t_fields;
      u_host.wr(OFF_GIG_EXT_ONE, 16'hffff);
      rdc(OFF_GIG_EXT_ONE, GIG_EXT_ONE_VAL);
      u_host.wr(OFF_BYPASS, 16'hffff);
      rdc(OFF_BYPASS, 16'h81fb);
      for (int k = 0; k < 9; k++) begin
         u_host.wr(OFF_BYPASS, 16'h1 << ctrl_pos[k]);
         #1;
         check({7'h00, ctrl}, 16'h1 << k);
         rdc(OFF_BYPASS, 16'h1 << ctrl_pos[k]);
      end
   endtask

   task automatic t_soft;
      u_host.wr(OFF_BYPASS, 16'hffff);
      ev(pse_evt_t'(6'h20), pse_evt_t'(6'h01), 1'b1);
      @(posedge clock);
      soft_reset <= 1'b1;
      @(posedge clock);
      soft_reset <= 1'b0;
      rdc(OFF_FE_EXT, 16'h0000);
      // sticky forced legacy detection still shows in bit 6
      rdc(OFF_GIG_EXT_TWO, 16'h0040);
      rdc(OFF_BYPASS, 16'h00fb);
      check({7'h00, ctrl}, 16'h007f);
   endtask

   task automatic t_next_page;
      u_host.wr(OFF_BYPASS, 16'h0049);
      pg(1'b1, 1'b0);
      check({15'h0000, np_host}, 16'h0000);
      u_host.wr(OFF_BYPASS, 16'h004b);
      pg(1'b1, 1'b0);
      check({15'h0000, np_host}, 16'h0001);
      u_host.force_cfg(16'h004b);
      check({15'h0000, np_host}, 16'h0001);
      pg(1'b0, 1'b1);
      check({15'h0000, np_host}, 16'h0000);
   endtask

   task automatic t_hw_reset;
      u_host.wr(OFF_BYPASS, 16'hffff);
      @(posedge clock);
      strap  <= 1'b0;
      resetn <= 1'b0;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      rdc(OFF_BYPASS, 16'h0048);
      check({7'h00, ctrl}, 16'h0024);
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         final_report();
      end
   end

   initial begin
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      t_reset_values();
      t_live();
      t_events();
      t_legacy();
      t_fields();
      t_soft();
      t_next_page();
      t_hw_reset();
      final_report();
   end
endmodule
`default_nettype wire
